// File: rtl/kssl_pkg.sv
// Operation
// R1: Terminal sends command bytes back to back, free clock; code starts one per byte period, line idle after each frame
// R2: Scan bit once per field, keyboard pulses start
// R3: One data bit per sixteen link clocks
// R4: Terminator key always loads the transmitter
// R5: Transmitter empty drops while key bytes send
// R6: Scan counter pauses while transmitter busy
// R7: Counters held clear until next scan start
// R8: Processor writes status byte each empty flag
// R9: Received byte sets ready flag and interrupt
// R10: Read strobe clears the receive ready flag
// R11: Link clock made from two line-address taps
// R12: Empty scan marks keyboard failed, code 4
// R13: Both ends use the same byte framing
package kssl_pkg;
  // Link timing
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned BYTE_PERIOD_NS  = 1280000;
  localparam int unsigned BYTE_PERIOD_CYC = BYTE_PERIOD_NS / 40;
  localparam int unsigned FIELD_HZ        = 60;
  localparam int unsigned FIELD_CYC       = CLK_HZ / FIELD_HZ;
  localparam int unsigned OVERSAMPLE      = 16;
  localparam int unsigned FRAME_BITS      = 10;
  localparam int unsigned FAIL_CODE       = 4;
  // Command byte fields
  localparam int unsigned CMD_SCAN_BIT    = 6;
  localparam logic [7:0]  TERMINATOR_KEY  = 8'h7F;
  // Register offsets
  localparam logic [7:0]  REG_STATUS_OFS  = 8'h00;
  localparam logic [7:0]  REG_MASK_OFS    = 8'h04;
  localparam logic [7:0]  REG_TXDATA_OFS  = 8'h08;
  localparam logic [7:0]  REG_RXDATA_OFS  = 8'h0C;
  localparam logic [7:0]  REG_CTRL_OFS    = 8'h10;
  // Status bits
  localparam int unsigned ST_RX_READY     = 0;
  localparam int unsigned ST_TX_EMPTY     = 1;
  localparam int unsigned ST_KBD_FAIL     = 2;
  localparam logic [2:0]  MASK_RESET      = 3'h0;
  localparam logic [7:0]  TXDATA_RESET    = 8'h00;
endpackage : kssl_pkg

// File: rtl/kssl_link_if.sv
`timescale 1ns/1ps
// Wires between terminal and keyboard
interface kssl_link_if;
  logic link_clk;
  logic line_addr_tap_a;
  logic line_addr_tap_b;
  logic term_to_kbd;
  logic kbd_to_term;
  modport terminal (output link_clk, output term_to_kbd, input kbd_to_term,
                    output line_addr_tap_a, output line_addr_tap_b);
  modport keyboard (input link_clk, input term_to_kbd, output kbd_to_term);
endinterface : kssl_link_if

// File: rtl/kssl_keyboard.sv
`timescale 1ns/1ps
module kssl_keyboard
  import kssl_pkg::*;
#(
  parameter int unsigned KEYS = 128
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // Link
  kssl_link_if.keyboard    link,
  // Key matrix
  input  wire logic [KEYS-1:0] i_keys_down,
  // Status
  output logic [7:0]       o_cmd_byte,
  output logic             o_scan_start_n
);
  typedef enum logic [2:0] {KS_IDLE = 3'b001, KS_SCAN = 3'b010, KS_DONE = 3'b100} kssl_ks_t;
  kssl_ks_t    st_reg, st_next;
  logic [6:0]  addr_reg, addr_next;
  logic        ck_d_reg, rx_d_reg;
  logic [3:0]  rph_reg, rph_next, tph_reg, tph_next;
  logic [3:0]  rbit_reg, rbit_next, tbit_reg, tbit_next;
  logic [7:0]  rsh_reg, rsh_next, cmd_reg, cmd_next;
  logic        rbusy_reg, rbusy_next, start_n_reg, start_n_next;
  logic [9:0]  tsh_reg, tsh_next;
  logic        tx_buffer_empty;
  logic        lrise, key_down_n;
  assign lrise = link.link_clk & ~ck_d_reg;
  assign tx_buffer_empty = (tbit_reg == 4'h0);
  assign key_down_n = ~(i_keys_down[addr_reg] | (addr_reg == TERMINATOR_KEY[6:0]));
  // Next state: receiver, transmitter, scan
  always_comb begin
    rph_next = rph_reg; rbit_next = rbit_reg; rsh_next = rsh_reg;
    rbusy_next = rbusy_reg; cmd_next = cmd_reg; start_n_next = 1'b1;
    st_next = st_reg; addr_next = addr_reg;
    tph_next = tph_reg; tbit_next = tbit_reg; tsh_next = tsh_reg;
    if (lrise) begin
      // Receiver, sample mid-bit
      if (!rbusy_reg) begin
        if (!rx_d_reg) begin
          rbusy_next = 1'b1; rph_next = 4'h0; rbit_next = 4'h0;
        end
      end else begin
        rph_next = rph_reg + 4'h1;
        if (rph_reg == 4'(OVERSAMPLE/2 - 1)) begin // R3
          rbit_next = rbit_reg + 4'h1;
          if (rbit_reg >= 4'h1 && rbit_reg <= 4'h8) begin
            rsh_next = {rx_d_reg, rsh_reg[7:1]}; // R13
          end
          if (rbit_reg == 4'(FRAME_BITS - 1)) begin
            rbusy_next = 1'b0; cmd_next = rsh_reg;
            if (rsh_reg[CMD_SCAN_BIT]) begin
              start_n_next = 1'b0; // R2
            end
          end
        end
      end
      // Transmitter shifting
      if (!tx_buffer_empty) begin
        tph_next = tph_reg + 4'h1;
        if (tph_reg == 4'(OVERSAMPLE - 1)) begin // R3
          tsh_next = {1'b1, tsh_reg[9:1]};
          tbit_next = tbit_reg - 4'h1;
        end
      end
      // Scan counter, paused while transmitter busy
      case (st_reg)
        KS_IDLE: addr_next = 7'h00; // R7
        KS_SCAN: begin
          if (tx_buffer_empty) begin // R6
            if (!key_down_n) begin
              tsh_next = {1'b1, 1'b0, addr_reg, 1'b0}; // R4 R5
              tbit_next = 4'(FRAME_BITS); tph_next = 4'h0;
            end
            if (addr_reg == TERMINATOR_KEY[6:0]) st_next = KS_DONE;
            else addr_next = addr_reg + 7'h1;
          end
        end
        KS_DONE: addr_next = 7'h00; // R7
        default: st_next = KS_IDLE;
      endcase
    end
    if (!start_n_reg) begin
      st_next = KS_SCAN; addr_next = 7'h00; // R7
    end
  end
  // Register update
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_reg <= KS_IDLE; addr_reg <= 7'h00; ck_d_reg <= 1'b0; rx_d_reg <= 1'b1;
      rph_reg <= 4'h0; rbit_reg <= 4'h0; rsh_reg <= 8'h00; rbusy_reg <= 1'b0;
      cmd_reg <= 8'h00; start_n_reg <= 1'b1; tph_reg <= 4'h0; tbit_reg <= 4'h0;
      tsh_reg <= 10'h3FF;
    end else begin
      st_reg <= st_next; addr_reg <= addr_next; ck_d_reg <= link.link_clk;
      rx_d_reg <= link.term_to_kbd; rph_reg <= rph_next; rbit_reg <= rbit_next;
      rsh_reg <= rsh_next; rbusy_reg <= rbusy_next; cmd_reg <= cmd_next;
      start_n_reg <= start_n_next; tph_reg <= tph_next; tbit_reg <= tbit_next;
      tsh_reg <= tsh_next;
    end
  end
  assign link.kbd_to_term = tsh_reg[0];
  assign o_cmd_byte = cmd_reg;
  assign o_scan_start_n = start_n_reg;
endmodule : kssl_keyboard

// File: rtl/kssl_terminal.sv
`timescale 1ns/1ps
module kssl_terminal
  import kssl_pkg::*;
#(
  parameter int unsigned BYTE_CYC  = BYTE_PERIOD_CYC,
  parameter int unsigned FIELD_LEN = FIELD_CYC
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Interrupt
  output logic             o_irq,
  // Link
  kssl_link_if.terminal    link
);
  logic [31:0] lba_reg, lba_next;
  logic [31:0] bcnt_reg, bcnt_next, fcnt_reg, fcnt_next;
  logic        scan_pend_reg, scan_pend_next, scan_wait_reg, scan_wait_next;
  logic [3:0]  tph_reg, tph_next, tbit_reg, tbit_next;
  logic [9:0]  tsh_reg, tsh_next;
  logic [7:0]  txd_reg, txd_next, rxd_reg, rxd_next;
  logic        ck_d_reg, rx_d_reg, rbusy_reg, rbusy_next;
  logic [3:0]  rph_reg, rph_next, rbit_reg, rbit_next;
  logic [7:0]  rsh_reg, rsh_next;
  logic [2:0]  st_reg, st_next, mask_reg, mask_next;
  logic        fail_reg, fail_next;
  logic        wr_ph_reg, wr_ph_next, rd_ph_reg, rd_ph_next;
  logic [7:0]  ad_reg, ad_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        link_clk, lrise, kbd_rx_ready, kbd_tx_empty;
  logic        kbd_uart_write_n, kbd_uart_read_n, rx_done, byte_tick, addr_ok;
  // Link clock from two line-address taps
  assign link_clk = lba_reg[3] ^ lba_reg[4]; // R11
  assign lrise = link_clk & ~ck_d_reg;
  assign byte_tick = (bcnt_reg == BYTE_CYC - 1);
  assign kbd_rx_ready = st_reg[ST_RX_READY];
  assign kbd_tx_empty = st_reg[ST_TX_EMPTY];
  assign addr_ok = i_hsel & i_hready & i_htrans[1];
  assign kbd_uart_write_n = ~(wr_ph_reg && ad_reg == REG_TXDATA_OFS);
  assign kbd_uart_read_n = ~(rd_ph_reg && ad_reg == REG_RXDATA_OFS);
  // Timing, transmitter, receiver, bus
  always_comb begin
    lba_next = lba_reg + 32'h1;
    bcnt_next = byte_tick ? 32'h0 : bcnt_reg + 32'h1;
    fcnt_next = (fcnt_reg == FIELD_LEN - 1) ? 32'h0 : fcnt_reg + 32'h1;
    scan_pend_next = scan_pend_reg | (fcnt_reg == FIELD_LEN - 1); // R2
    scan_wait_next = scan_wait_reg;
    tph_next = tph_reg; tbit_next = tbit_reg; tsh_next = tsh_reg; txd_next = txd_reg;
    rph_next = rph_reg; rbit_next = rbit_reg; rsh_next = rsh_reg;
    rbusy_next = rbusy_reg; rxd_next = rxd_reg; rx_done = 1'b0;
    st_next = st_reg; mask_next = mask_reg; fail_next = fail_reg;
    // Start a new command byte every byte period
    if (byte_tick) begin // R1
      tsh_next = {1'b1, txd_reg | (scan_pend_reg ? 8'(1 << CMD_SCAN_BIT) : 8'h00), 1'b0};
      tbit_next = 4'(FRAME_BITS); tph_next = 4'h0;
      st_next[ST_TX_EMPTY] = 1'b1; // R8
      if (scan_pend_reg) begin
        if (scan_wait_reg) fail_next = 1'b1; // R12
        scan_pend_next = 1'b0; scan_wait_next = 1'b1;
      end
    end
    if (lrise) begin
      if (tbit_reg != 4'h0) begin
        tph_next = tph_reg + 4'h1;
        if (tph_reg == 4'(OVERSAMPLE - 1)) begin // R3
          tsh_next = {1'b1, tsh_reg[9:1]}; tbit_next = tbit_reg - 4'h1;
        end
      end
      if (!rbusy_reg) begin
        if (!rx_d_reg) begin
          rbusy_next = 1'b1; rph_next = 4'h0; rbit_next = 4'h0;
        end
      end else begin
        rph_next = rph_reg + 4'h1;
        if (rph_reg == 4'(OVERSAMPLE/2 - 1)) begin // R3
          rbit_next = rbit_reg + 4'h1;
          if (rbit_reg >= 4'h1 && rbit_reg <= 4'h8) rsh_next = {rx_d_reg, rsh_reg[7:1]}; // R13
          if (rbit_reg == 4'(FRAME_BITS - 1)) begin
            rbusy_next = 1'b0; rxd_next = rsh_reg; rx_done = 1'b1;
          end
        end
      end
    end
    if (rx_done) begin
      scan_wait_next = 1'b0;
      if (rsh_reg == TERMINATOR_KEY) fail_next = 1'b0;
    end
    // Bus writes; hardware set wins over clear
    if (!kbd_uart_write_n) begin
      txd_next = i_hwdata[7:0]; st_next[ST_TX_EMPTY] = 1'b0; // R8
    end
    if (wr_ph_reg && ad_reg == REG_MASK_OFS) mask_next = i_hwdata[2:0];
    if (wr_ph_reg && ad_reg == REG_STATUS_OFS) st_next = st_next & ~i_hwdata[2:0];
    if (!kbd_uart_read_n) st_next[ST_RX_READY] = 1'b0; // R10
    if (rx_done) st_next[ST_RX_READY] = 1'b1; // R9
    if (fail_next & ~fail_reg) st_next[ST_KBD_FAIL] = 1'b1; // R12
    if (byte_tick) st_next[ST_TX_EMPTY] = 1'b1;
    wr_ph_next = addr_ok & i_hwrite;
    rd_ph_next = addr_ok & ~i_hwrite;
    ad_next = addr_ok ? {i_haddr[7:2], 2'b00} : ad_reg;
    case ({i_haddr[7:2], 2'b00})
      REG_STATUS_OFS: rdata_next = {29'h0, st_reg};
      REG_MASK_OFS:   rdata_next = {29'h0, mask_reg};
      REG_TXDATA_OFS: rdata_next = {24'h0, txd_reg};
      REG_RXDATA_OFS: rdata_next = {24'h0, rxd_reg};
      REG_CTRL_OFS:   rdata_next = fail_reg ? 32'(FAIL_CODE) : 32'h0; // R12
      default:        rdata_next = 32'h0;
    endcase
    if (!(addr_ok & ~i_hwrite)) rdata_next = rdata_reg;
  end
  // Register update
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      lba_reg <= 32'h0; bcnt_reg <= 32'h0; fcnt_reg <= 32'h0; scan_pend_reg <= 1'b0;
      scan_wait_reg <= 1'b0; tph_reg <= 4'h0; tbit_reg <= 4'h0; tsh_reg <= 10'h3FF;
      txd_reg <= TXDATA_RESET; rxd_reg <= 8'h00; ck_d_reg <= 1'b0; rx_d_reg <= 1'b1;
      rbusy_reg <= 1'b0; rph_reg <= 4'h0; rbit_reg <= 4'h0; rsh_reg <= 8'h00;
      st_reg <= 3'h0; mask_reg <= MASK_RESET; fail_reg <= 1'b0; wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0; ad_reg <= 8'h00; rdata_reg <= 32'h0;
    end else begin
      lba_reg <= lba_next; bcnt_reg <= bcnt_next; fcnt_reg <= fcnt_next;
      scan_pend_reg <= scan_pend_next; scan_wait_reg <= scan_wait_next;
      tph_reg <= tph_next; tbit_reg <= tbit_next; tsh_reg <= tsh_next; txd_reg <= txd_next;
      rxd_reg <= rxd_next; ck_d_reg <= link_clk; rx_d_reg <= link.kbd_to_term;
      rbusy_reg <= rbusy_next; rph_reg <= rph_next; rbit_reg <= rbit_next;
      rsh_reg <= rsh_next; st_reg <= st_next; mask_reg <= mask_next; fail_reg <= fail_next;
      wr_ph_reg <= wr_ph_next; rd_ph_reg <= rd_ph_next; ad_reg <= ad_next;
      rdata_reg <= rdata_next;
    end
  end
  // Outputs
  assign link.link_clk = link_clk; // R1
  assign link.line_addr_tap_a = lba_reg[3];
  assign link.line_addr_tap_b = lba_reg[4];
  assign link.term_to_kbd = tsh_reg[0];
  assign o_hrdata = rdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_irq = |(st_reg & mask_reg); // R9
endmodule : kssl_terminal

// File: verification/kssl_link_assertions.sv
`timescale 1ns/1ps
module kssl_link_assertions #(
  parameter int unsigned BYTE_CYC = 32000
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Link wires
  input wire logic link_clk,
  input wire logic line_addr_tap_a,
  input wire logic line_addr_tap_b,
  input wire logic term_to_kbd,
  input wire logic kbd_to_term
);
  logic [1:0]  ln;
  logic [1:0]  ln_reg;
  logic [1:0]  start;
  logic [15:0] bit_reg [2];
  logic [15:0] frm_reg [2];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Line 0 carries commands, line 1 keys
  assign ln = {kbd_to_term, term_to_kbd};
  // Frame start is a fall at least nine bit times (4608 cycles) after the last frame start
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      start[k] = !ln[k] && ln_reg[k] && (frm_reg[k] >= 16'd4608);
    end
  end
  // Saturating cycle counts since last edge and since frame start
  always_ff @(posedge i_clock) begin
    ln_reg <= ln;
    for (int k = 0; k < 2; k++) begin
      if (i_reset) begin
        bit_reg[k] <= 16'hFFFF;
        frm_reg[k] <= 16'hFFFF;
      end else begin
        bit_reg[k] <= (ln[k] != ln_reg[k]) ? 16'h0 : bit_reg[k] + {15'h0, bit_reg[k] != 16'hFFFF};
        frm_reg[k] <= start[k] ? 16'h0 : frm_reg[k] + {15'h0, frm_reg[k] != 16'hFFFF};
      end
    end
  end
  chk_clk_from_taps: assert property (link_clk == (line_addr_tap_a ^ line_addr_tap_b))
    else $error("link clock not made from taps");
  chk_tap_a_period: assert property ($changed(line_addr_tap_a) |=>
    $stable(line_addr_tap_a)[*7] ##1 $changed(line_addr_tap_a)) else $error("tap a period");
  chk_tap_b_carry: assert property ($changed(line_addr_tap_b) |-> $fell(line_addr_tap_a))
    else $error("tap b moved without carry");
  chk_link_clk_runs: assert property (1'b1 |-> ##[1:32] $changed(link_clk))
    else $error("link clock stopped");
  chk_cmd_bit_time: assert property ((ln[0] != ln_reg[0]) |-> bit_reg[0] >= 16'd479)
    else $error("command bit too short");
  chk_key_bit_time: assert property ((ln[1] != ln_reg[1]) |-> bit_reg[1] >= 16'd510)
    else $error("key bit too short");
  chk_cmd_start_bit: assert property (frm_reg[0] == 16'd255 |-> !term_to_kbd)
    else $error("command start bit lost");
  chk_cmd_stop_bit: assert property (frm_reg[0] == 16'd4863 |-> term_to_kbd)
    else $error("command stop bit low");
  chk_key_stop_bit: assert property (frm_reg[1] == 16'd4863 |-> kbd_to_term)
    else $error("key stop bit low");
  chk_cmd_byte_spacing: assert property ((start[0] && frm_reg[0] != 16'hFFFF) |->
    frm_reg[0] == 16'(BYTE_CYC - 1)) else $error("command byte spacing");
endmodule : kssl_link_assertions

// File: verification/keyboard_scan_serial_link_tb.sv
`timescale 1ns/1ps
module keyboard_scan_serial_link_tb;
  import kssl_pkg::*;
  // Link clock period is 32 cycles, so a frame takes 5120 cycles
  localparam int unsigned BYTE  = 5248;
  localparam int unsigned FIELD = 20992;
  logic         i_clock = 1'b0;
  logic         i_reset = 1'b1;
  logic         sel2    = 1'b0;
  logic         hsel    = 1'b0;
  logic [7:0]   haddr   = 8'h00;
  logic [1:0]   htrans  = 2'h0;
  logic         hwrite  = 1'b0;
  logic [31:0]  hwdata  = 32'h0;
  logic [127:0] keys    = '0;
  logic         hready;
  logic [31:0]  hrd [2];
  logic [1:0]   hro;
  logic [1:0]   irq;
  logic [7:0]   cmd;
  logic         scan_n;
  int           failures = 0;
  int           check_count = 0;
  kssl_link_if kssl_link_if_i ();
  kssl_link_if fail_link_i ();
  // Second terminal faces a keyboard that never answers
  assign fail_link_i.kbd_to_term = 1'b1;
  assign hready = hro[sel2];
  // Clock
  always #20 i_clock = ~i_clock;
  kssl_terminal #(.BYTE_CYC(BYTE), .FIELD_LEN(FIELD)) kssl_terminal_i (.i_clock(i_clock),
    .i_reset(i_reset), .i_hsel(hsel & !sel2), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrd[0]), .o_hreadyout(hro[0]), .o_hresp(), .o_irq(irq[0]), .link(kssl_link_if_i));
  kssl_terminal #(.BYTE_CYC(BYTE), .FIELD_LEN(FIELD)) fail_terminal_i (.i_clock(i_clock),
    .i_reset(i_reset), .i_hsel(hsel & sel2), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrd[1]), .o_hreadyout(hro[1]), .o_hresp(), .o_irq(irq[1]), .link(fail_link_i));
  kssl_keyboard kssl_keyboard_i (.i_clock(i_clock), .i_reset(i_reset), .link(kssl_link_if_i),
    .i_keys_down(keys), .o_cmd_byte(cmd), .o_scan_start_n(scan_n));
  kssl_link_assertions #(.BYTE_CYC(BYTE)) kssl_link_assertions_i (.i_clock(i_clock),
    .i_reset(i_reset), .link_clk(kssl_link_if_i.link_clk),
    .line_addr_tap_a(kssl_link_if_i.line_addr_tap_a),
    .line_addr_tap_b(kssl_link_if_i.line_addr_tap_b),
    .term_to_kbd(kssl_link_if_i.term_to_kbd), .kbd_to_term(kssl_link_if_i.kbd_to_term));
  // Verdict and end of run
  task finish_test;
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task bail;
    failures++;
    finish_test();
  endtask : bail
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    @(posedge i_clock);
    while (hready !== 1'b1) begin
      n++;
      if (n > 16) bail();
      @(posedge i_clock);
    end
  endtask : wait_rdy
  // One single AHB transfer, address then data phase
  task bus(input logic t, input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    sel2 <= t;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrd[t];
  endtask : bus
  task wr(input logic t, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(t, 1'b1, a, d, x);
  endtask : wr
  task rdc(input logic t, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
           input string nm);
    logic [31:0] x;
    bus(t, 1'b0, a, 32'h0, x);
    chk(nm, e, x & m);
  endtask : rdc
  task poll(input int bitno, input int lim);
    logic [31:0] x;
    int n;
    n = 0;
    do begin
      bus(1'b0, 1'b0, REG_STATUS_OFS, 32'h0, x);
      n++;
      if (n > lim) bail();
    end while (x[bitno] !== 1'b1);
  endtask : poll
  task get_byte(input logic [7:0] e);
    int n;
    n = 0;
    repeat (2) @(posedge i_clock);
    while (irq[0] !== 1'b1) begin
      n++;
      if (n > 2 * FIELD) bail();
      @(posedge i_clock);
    end
    rdc(1'b0, REG_RXDATA_OFS, 32'hFF, {24'h0, e}, "rx byte");
  endtask : get_byte
  task t_reset;
    rdc(1'b0, REG_MASK_OFS, 32'hFFFFFFFF, 32'h0, "mask reset");
    rdc(1'b0, REG_CTRL_OFS, 32'hFFFFFFFF, 32'h0, "no fail code");
    rdc(1'b0, 8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk("irq idle", 32'h0, {31'h0, irq[0]});
  endtask : t_reset
  task t_scan_empty;
    wr(1'b0, REG_MASK_OFS, 32'h1);
    get_byte(TERMINATOR_KEY);
    repeat (2) @(posedge i_clock);
    chk("irq after read", 32'h0, {31'h0, irq[0]});
  endtask : t_scan_empty
  task t_scan_keys;
    keys <= (128'h1 << 5) | (128'h1 << 20);
    get_byte(8'h05);
    get_byte(8'h14);
    get_byte(TERMINATOR_KEY);
    keys <= '0;
  endtask : t_scan_keys
  task t_mask;
    wr(1'b0, REG_MASK_OFS, 32'h0);
    poll(0, FIELD);
    chk("masked irq", 32'h0, {31'h0, irq[0]});
    wr(1'b0, REG_STATUS_OFS, 32'h1);
    rdc(1'b0, REG_STATUS_OFS, 32'h1, 32'h0, "rx cleared");
    wr(1'b0, REG_MASK_OFS, 32'h1);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 32'h0, {31'h0, irq[0]});
  endtask : t_mask
  task t_tx;
    int n;
    poll(1, BYTE);
    wr(1'b0, REG_TXDATA_OFS, 32'h05);
    rdc(1'b0, REG_STATUS_OFS, 32'h2, 32'h0, "tx busy");
    n = 0;
    while ((cmd & 8'hBF) !== 8'h05) begin
      n++;
      if (n > 3 * BYTE) bail();
      @(posedge i_clock);
    end
    chk("cmd byte", 32'h05, {24'h0, cmd & 8'hBF});
  endtask : t_tx
  task t_scan_pulses;
    int p;
    p = 0;
    repeat (FIELD) begin
      @(posedge i_clock);
      if (scan_n === 1'b0) p++;
    end
    chk("scan starts", 32'd1, p);
  endtask : t_scan_pulses
  task t_fail;
    rdc(1'b1, REG_CTRL_OFS, 32'hFF, 32'h4, "fail code");
    rdc(1'b1, REG_STATUS_OFS, 32'h4, 32'h4, "fail flag");
    rdc(1'b0, REG_CTRL_OFS, 32'hFF, 32'h0, "keyboard alive");
  endtask : t_fail
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    t_reset();
    t_tx();
    t_scan_pulses();
    t_scan_empty();
    t_scan_keys();
    t_mask();
    t_fail();
    finish_test();
  end
endmodule : keyboard_scan_serial_link_tb
